// file: core/ckgc_params.svh
// offsets, field positions, reset values and timing counts of the clock control block
`ifndef CKGC_PARAMS_SVH
`define CKGC_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CKGC_OFF_PCLK_EN 12'h010
`define CKGC_OFF_PCLK_DIS 12'h014
`define CKGC_OFF_PCLK_STAT 12'h018
`define CKGC_OFF_OSC_CTL 12'h020
`define CKGC_OFF_MEASURE 12'h024
`define CKGC_OFF_PLL 12'h02C
`define CKGC_OFF_MCK 12'h030
`define CKGC_OFF_PCK_BASE 12'h040
`define CKGC_OFF_IRQ_EN 12'h060
`define CKGC_OFF_IRQ_DIS 12'h064
`define CKGC_OFF_STATUS 12'h068
`define CKGC_OFF_IRQ_MASK 12'h06C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CKGC_OSC_EN_BIT 0
`define CKGC_OSC_PASS_BIT 1
`define CKGC_OSC_DLY_LSB 8
`define CKGC_MEAS_VALID_BIT 16
`define CKGC_PLL_DIV_LSB 0
`define CKGC_PLL_SETTLE_LSB 8
`define CKGC_PLL_RANGE_LSB 14
`define CKGC_PLL_MUL_LSB 16
`define CKGC_PLL_USB_LSB 28
`define CKGC_CSS_LSB 0
`define CKGC_CLOCK_OUTPUT_RATIO_LSB 2
`define CKGC_ST_OSC_BIT 0
`define CKGC_ST_LOCK_BIT 2
`define CKGC_ST_MCK_BIT 3
`define CKGC_ST_PCK_LSB 8

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CKGC_PLL_RESET 32'h00003F00
`define CKGC_PCLK_IMPL 32'hFFFFFFFC
`define CKGC_MEAS_PERIODS 5'h10
`define CKGC_MCK_RDY_CYCLES 4'h4
`define CKGC_PCK_RDY_CYCLES 4'h4

`endif

// file: core/ckgc_pkg.sv
// types of the clock control block
package ckgc_pkg;

	typedef struct packed {
		logic [7:0] startup_delay;
		logic passthrough;
		logic enable;
	} ckgc_osc_cfg_t;

	typedef struct packed {
		logic [1:0] usb_clock_ratio;
		logic [10:0] pll_feedback_factor;
		logic [1:0] range;
		logic [5:0] pll_settle_delay;
		logic [7:0] divider;
	} ckgc_pll_cfg_t;

	typedef struct packed {
		logic [2:0] clock_output_ratio;
		logic [1:0] clock_source_select;
	} ckgc_sel_cfg_t;

	typedef enum logic [1:0] {
		CKGC_SRC_SLOW = 2'b00,
		CKGC_SRC_MAIN = 2'b01,
		CKGC_SRC_PLLA = 2'b10,
		CKGC_SRC_PLLB = 2'b11
	} ckgc_src_t;

endpackage : ckgc_pkg

// file: core/ckgc_top.sv
// clock control registers with an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "ckgc_params.svh"

module ckgc_top #(
	parameter int NUM_PCK = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic slow_clk_tick,
	input wire logic main_clk_tick,
	output logic [31:0] periph_clk_en,
	output ckgc_pkg::ckgc_osc_cfg_t osc_cfg,
	output ckgc_pkg::ckgc_pll_cfg_t pll_cfg,
	output logic pll_running,
	output logic pll_div_bypass,
	output logic [2:0] usb_div_log2,
	output ckgc_pkg::ckgc_sel_cfg_t mck_cfg,
	output logic mck_pll_sel,
	output logic [6:0] mck_div,
	output ckgc_pkg::ckgc_sel_cfg_t [NUM_PCK-1:0] pck_cfg,
	output logic [6:0] pck_div [NUM_PCK],
	output logic irq
);

	// ----------------------------------------
	// axi4-lite write address, data and response channels
	// ----------------------------------------
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [11:0] waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;

	wire do_write = !awready_ff && !wready_ff && !bvalid_ff;
	wire full_word = wstrb_ff == 4'hF;
	wire [11:0] pck_top = 12'(`CKGC_OFF_PCK_BASE + 4 * NUM_PCK);

	wire wr_pclk_en = do_write && full_word && waddr_ff == `CKGC_OFF_PCLK_EN;
	wire wr_pclk_dis = do_write && full_word && waddr_ff == `CKGC_OFF_PCLK_DIS;
	wire wr_osc = do_write && full_word && waddr_ff == `CKGC_OFF_OSC_CTL;
	wire wr_pll = do_write && full_word && waddr_ff == `CKGC_OFF_PLL;
	wire wr_mck = do_write && full_word && waddr_ff == `CKGC_OFF_MCK;
	wire wr_ien = do_write && full_word && waddr_ff == `CKGC_OFF_IRQ_EN;
	wire wr_idis = do_write && full_word && waddr_ff == `CKGC_OFF_IRQ_DIS;
	wire wr_pck_area = waddr_ff >= `CKGC_OFF_PCK_BASE && waddr_ff < pck_top;
	wire [11:0] wr_pck_rel = waddr_ff - `CKGC_OFF_PCK_BASE;
	wire w_mapped = waddr_ff == `CKGC_OFF_PCLK_EN || waddr_ff == `CKGC_OFF_PCLK_DIS
		|| waddr_ff == `CKGC_OFF_OSC_CTL || waddr_ff == `CKGC_OFF_PLL
		|| waddr_ff == `CKGC_OFF_MCK || waddr_ff == `CKGC_OFF_IRQ_EN
		|| waddr_ff == `CKGC_OFF_IRQ_DIS || wr_pck_area;
	wire w_ok = w_mapped && waddr_ff[1:0] == 2'h0 && full_word;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			waddr_ff <= 12'h000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				waddr_ff <= awaddr;
			end
			if (wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= w_ok ? 2'h0 : 2'h2;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [31:0] pclk_en_ff;
	ckgc_pkg::ckgc_osc_cfg_t osc_ff;
	ckgc_pkg::ckgc_pll_cfg_t pll_ff;
	ckgc_pkg::ckgc_sel_cfg_t mck_ff;
	logic [11:0] imask_ff;
	logic irq_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pclk_en_ff <= 32'h00000000;
			osc_ff <= '0;
			pll_ff <= ckgc_pkg::ckgc_pll_cfg_t'(29'(`CKGC_PLL_RESET));
			mck_ff <= '0;
			imask_ff <= 12'h000;
		end else begin
			if (wr_pclk_en)
				pclk_en_ff <= pclk_en_ff | (wdata_ff & `CKGC_PCLK_IMPL);
			if (wr_pclk_dis)
				pclk_en_ff <= pclk_en_ff & ~(wdata_ff & `CKGC_PCLK_IMPL);
			if (wr_osc) begin
				osc_ff.enable <= wdata_ff[`CKGC_OSC_EN_BIT];
				osc_ff.passthrough <= wdata_ff[`CKGC_OSC_PASS_BIT];
				osc_ff.startup_delay <= wdata_ff[`CKGC_OSC_DLY_LSB +: 8];
			end
			if (wr_pll) begin
				pll_ff.divider <= wdata_ff[`CKGC_PLL_DIV_LSB +: 8];
				pll_ff.pll_settle_delay <= wdata_ff[`CKGC_PLL_SETTLE_LSB +: 6];
				pll_ff.range <= wdata_ff[`CKGC_PLL_RANGE_LSB +: 2];
				pll_ff.pll_feedback_factor <= wdata_ff[`CKGC_PLL_MUL_LSB +: 11];
				pll_ff.usb_clock_ratio <= wdata_ff[`CKGC_PLL_USB_LSB +: 2];
			end
			if (wr_mck) begin
				mck_ff.clock_source_select <= wdata_ff[`CKGC_CSS_LSB +: 2];
				mck_ff.clock_output_ratio <= wdata_ff[`CKGC_CLOCK_OUTPUT_RATIO_LSB +: 3];
			end
			if (wr_ien)
				imask_ff <= imask_ff | wdata_ff[11:0];
			if (wr_idis)
				imask_ff <= imask_ff & ~wdata_ff[11:0];
		end
	end

	// ----------------------------------------
	// oscillator start-up
	// ----------------------------------------
	logic [10:0] osc_cnt_ff;
	logic osc_stable_ff;
	wire [10:0] osc_wait = {osc_ff.startup_delay, 3'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_cnt_ff <= 11'h000;
			osc_stable_ff <= 1'b0;
		end else if (osc_ff.passthrough && !osc_ff.enable) begin
			osc_cnt_ff <= 11'h000;
			osc_stable_ff <= 1'b1;
		end else if (!osc_ff.enable) begin
			osc_cnt_ff <= 11'h000;
			osc_stable_ff <= 1'b0;
		end else if (!osc_stable_ff && slow_clk_tick) begin
			if (osc_cnt_ff >= osc_wait)
				osc_stable_ff <= 1'b1;
			else
				osc_cnt_ff <= osc_cnt_ff + 11'h001;
		end
	end

	// ----------------------------------------
	// main clock measurement
	// ----------------------------------------
	logic [4:0] meas_win_ff;
	logic [15:0] meas_cnt_ff, meas_val_ff;
	logic meas_valid_ff;
	wire meas_end = slow_clk_tick && meas_win_ff == `CKGC_MEAS_PERIODS - 5'h01;
	wire [15:0] meas_inc = meas_cnt_ff + {15'h0000, main_clk_tick && meas_cnt_ff != 16'hFFFF};

	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_stable_ff) begin
			meas_win_ff <= 5'h00;
			meas_cnt_ff <= 16'h0000;
			meas_val_ff <= 16'h0000;
			meas_valid_ff <= 1'b0;
		end else if (meas_end) begin
			meas_win_ff <= 5'h00;
			meas_cnt_ff <= 16'h0000;
			meas_val_ff <= meas_inc;
			meas_valid_ff <= 1'b1;
		end else begin
			meas_cnt_ff <= meas_inc;
			if (slow_clk_tick)
				meas_win_ff <= meas_win_ff + 5'h01;
		end
	end

	// ----------------------------------------
	// pll lock wait
	// ----------------------------------------
	logic [5:0] pll_cnt_ff;
	logic pll_busy_ff, lock_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_cnt_ff <= 6'h00;
			pll_busy_ff <= 1'b1;
			lock_ff <= 1'b0;
		end else if (wr_pll) begin
			pll_cnt_ff <= 6'h00;
			pll_busy_ff <= 1'b1;
			lock_ff <= 1'b0;
		end else if (pll_busy_ff && slow_clk_tick) begin
			if (pll_cnt_ff + 6'h01 >= pll_ff.pll_settle_delay) begin
				pll_busy_ff <= 1'b0;
				lock_ff <= 1'b1;
			end else
				pll_cnt_ff <= pll_cnt_ff + 6'h01;
		end
	end

	// ----------------------------------------
	// master and programmable clock ready
	// ----------------------------------------
	logic [3:0] mck_cnt_ff;
	logic mck_rdy_ff;
	ckgc_pkg::ckgc_sel_cfg_t [NUM_PCK-1:0] pck_ff;
	logic [NUM_PCK-1:0] pck_rdy_ff;
	logic [6:0] pck_div_ff [NUM_PCK];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mck_cnt_ff <= 4'h0;
			mck_rdy_ff <= 1'b1;
		end else if (wr_mck) begin
			mck_cnt_ff <= 4'h0;
			mck_rdy_ff <= 1'b0;
		end else if (!mck_rdy_ff) begin
			if (mck_cnt_ff == `CKGC_MCK_RDY_CYCLES - 4'h1)
				mck_rdy_ff <= 1'b1;
			else
				mck_cnt_ff <= mck_cnt_ff + 4'h1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PCK; gi++) begin : g_pck
			logic [3:0] cnt_ff;
			wire wr_this = do_write && full_word && wr_pck_area && wr_pck_rel[11:2] == 10'(gi);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pck_ff[gi] <= '0;
					cnt_ff <= 4'h0;
					pck_rdy_ff[gi] <= 1'b1;
					pck_div_ff[gi] <= 7'h01;
				end else begin
					pck_div_ff[gi] <= 7'(7'h01 << pck_ff[gi].clock_output_ratio);
					if (wr_this) begin
						pck_ff[gi].clock_source_select <= wdata_ff[`CKGC_CSS_LSB +: 2];
						pck_ff[gi].clock_output_ratio <= wdata_ff[`CKGC_CLOCK_OUTPUT_RATIO_LSB +: 3];
						cnt_ff <= 4'h0;
						pck_rdy_ff[gi] <= 1'b0;
					end else if (!pck_rdy_ff[gi]) begin
						if (cnt_ff == `CKGC_PCK_RDY_CYCLES - 4'h1)
							pck_rdy_ff[gi] <= 1'b1;
						else
							cnt_ff <= cnt_ff + 4'h1;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// status and decoded outputs
	// ----------------------------------------
	logic [11:0] status;
	always_comb begin
		status = 12'h000;
		status[`CKGC_ST_OSC_BIT] = osc_stable_ff;
		status[`CKGC_ST_LOCK_BIT] = lock_ff;
		status[`CKGC_ST_MCK_BIT] = mck_rdy_ff;
		status[`CKGC_ST_PCK_LSB +: NUM_PCK] = pck_rdy_ff;
	end

	logic pll_run_ff, pll_byp_ff, mck_pll_ff;
	logic [2:0] usb_log2_ff;
	logic [6:0] mck_div_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
			pll_run_ff <= 1'b0;
			pll_byp_ff <= 1'b0;
			usb_log2_ff <= 3'h0;
			mck_pll_ff <= 1'b0;
			mck_div_ff <= 7'h01;
		end else begin
			irq_ff <= |(status & imask_ff);
			pll_run_ff <= pll_ff.divider != 8'h00 && pll_ff.pll_feedback_factor != 11'h000;
			pll_byp_ff <= pll_ff.divider == 8'h01;
			usb_log2_ff <= {1'b0, pll_ff.usb_clock_ratio};
			mck_pll_ff <= mck_ff.clock_source_select == 2'h3;
			mck_div_ff <= 7'(7'h01 << mck_ff.clock_output_ratio);
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	wire r_pck_area = araddr >= `CKGC_OFF_PCK_BASE && araddr < pck_top;
	wire [11:0] r_pck_rel = araddr - `CKGC_OFF_PCK_BASE;
	logic [31:0] rd_mux;
	logic rd_ok;

	always_comb begin
		rd_mux = 32'h00000000;
		rd_ok = araddr[1:0] == 2'h0;
		if (araddr == `CKGC_OFF_PCLK_STAT)
			rd_mux = pclk_en_ff & `CKGC_PCLK_IMPL;
		else if (araddr == `CKGC_OFF_OSC_CTL)
			rd_mux = {16'h0000, osc_ff.startup_delay, 6'h00, osc_ff.passthrough, osc_ff.enable};
		else if (araddr == `CKGC_OFF_MEASURE)
			rd_mux = {15'h0000, meas_valid_ff, meas_val_ff};
		else if (araddr == `CKGC_OFF_PLL)
			rd_mux = {2'h0, pll_ff.usb_clock_ratio, 1'b0, pll_ff.pll_feedback_factor,
				pll_ff.range, pll_ff.pll_settle_delay, pll_ff.divider};
		else if (araddr == `CKGC_OFF_MCK)
			rd_mux = {27'h0000000, mck_ff};
		else if (r_pck_area)
			rd_mux = {27'h0000000, pck_ff[r_pck_rel[11:2]]};
		else if (araddr == `CKGC_OFF_STATUS)
			rd_mux = {20'h00000, status};
		else if (araddr == `CKGC_OFF_IRQ_MASK)
			rd_mux = {20'h00000, imask_ff};
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'h0;
		end else begin
			if (arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_mux;
				rresp_ff <= rd_ok ? 2'h0 : 2'h2;
			end
			if (rvalid_ff && rready) begin
				rvalid_ff <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign periph_clk_en = pclk_en_ff;
	assign osc_cfg = osc_ff;
	assign pll_cfg = pll_ff;
	assign pll_running = pll_run_ff;
	assign pll_div_bypass = pll_byp_ff;
	assign usb_div_log2 = usb_log2_ff;
	assign mck_cfg = mck_ff;
	assign mck_pll_sel = mck_pll_ff;
	assign mck_div = mck_div_ff;
	assign pck_cfg = pck_ff;
	assign pck_div = pck_div_ff;
	assign irq = irq_ff;

endmodule : ckgc_top

`default_nettype wire

// file: core/unused_placeholder_none.sv
// no further content
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: test/ckgc_top_bench.sv
// self-checking bench of the clock control block
`timescale 1ns/100ps
`default_nettype none
`include "ckgc_params.svh"
module ckgc_top_bench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow_clk_tick, main_clk_tick;
	logic awready, wready, bvalid, arready, rvalid, pll_running, pll_div_bypass, mck_pll_sel, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, periph_clk_en, d, pen, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [2:0] usb_div_log2;
	logic [6:0] mck_div;
	logic [6:0] pck_div [4];
	ckgc_pkg::ckgc_osc_cfg_t osc_cfg;
	ckgc_pkg::ckgc_pll_cfg_t pll_cfg;
	ckgc_pkg::ckgc_sel_cfg_t mck_cfg;
	ckgc_pkg::ckgc_sel_cfg_t [3:0] pck_cfg;
	int miscompares, tests_run, seed, cyc;
	ckgc_top #(.NUM_PCK(4)) ckgc_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .slow_clk_tick(slow_clk_tick), .main_clk_tick(main_clk_tick),
		.periph_clk_en(periph_clk_en), .osc_cfg(osc_cfg), .pll_cfg(pll_cfg),
		.pll_running(pll_running), .pll_div_bypass(pll_div_bypass), .usb_div_log2(usb_div_log2),
		.mck_cfg(mck_cfg), .mck_pll_sel(mck_pll_sel), .mck_div(mck_div), .pck_cfg(pck_cfg),
		.pck_div(pck_div), .irq(irq));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// slow tick on every tenth cycle, main tick on odd: five main per slow period
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		slow_clk_tick <= (cyc % 10 == 8);
		main_clk_tick <= cyc[0];
	end
	// ----
	// tasks
	// ----
	task automatic conclude();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmpb(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask : cmpb
	task automatic wr(input logic [11:0] a, input logic [31:0] x, input logic [3:0] s);
		int n;
		awaddr <= a;
		wdata <= x;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (n == 3) bready <= 1'b1;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 50) miscompares++;
		if (n == 50) conclude();
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (n == 2) rready <= 1'b1;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 50) miscompares++;
		if (n == 50) conclude();
		@(posedge aclk);
	endtask : rd
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		cmp(v, e);
		cmp({30'h0, r}, 32'h0);
	endtask : rchk
	task automatic wbit(input int b, input logic e);
		int n;
		for (n = 0; n < 99; n++) begin
			rd(`CKGC_OFF_STATUS);
			if (v[b] === e) break;
		end
		cmpb(v[b], e);
		if (n == 99) conclude();
	endtask : wbit
	// ----
	// sequence
	// ----
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'hF;
		seed = 32'h0000CCDB;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(`CKGC_OFF_PLL, 32'h00003F00);
		rchk(`CKGC_OFF_OSC_CTL, 32'h0);
		rchk(`CKGC_OFF_IRQ_MASK, 32'h0);
		cmpb(irq, 1'b0);
		pen = 32'h0;
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			wr(`CKGC_OFF_PCLK_EN, d, 4'hF);
			pen = pen | (d & `CKGC_PCLK_IMPL);
			d = (i == 3) ? 32'h0 : $random(seed);
			wr(`CKGC_OFF_PCLK_DIS, d, 4'hF);
			pen = pen & ~d;
			rchk(`CKGC_OFF_PCLK_STAT, pen);
			cmp(periph_clk_en, pen);
		end
		wr(`CKGC_OFF_OSC_CTL, 32'h00000201, 4'hF);
		cmp({22'h0, osc_cfg}, 32'h00000009);
		repeat (100) @(posedge aclk);
		rd(`CKGC_OFF_STATUS);
		cmpb(v[0], 1'b0);
		wbit(0, 1'b1);
		rchk(`CKGC_OFF_MEASURE, 32'h0);
		repeat (400) @(posedge aclk);
		rchk(`CKGC_OFF_MEASURE, 32'h00010050);
		wr(`CKGC_OFF_OSC_CTL, 32'h0, 4'hF);
		rchk(`CKGC_OFF_MEASURE, 32'h0);
		wbit(0, 1'b0);
		wr(`CKGC_OFF_OSC_CTL, 32'h00000002, 4'hF);
		wbit(0, 1'b1);
		wr(`CKGC_OFF_OSC_CTL, 32'h0, 4'hF);
		for (int i = 0; i < 6; i++) begin
			d = $random(seed) & 32'h37FF3FFF;
			d[15] = i[0];
			d[13:8] = 6'h05;
			d[7:0] = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : d[7:0];
			d[26:16] = (i == 3) ? 11'h000 : (i == 4) ? 11'h7FF : d[26:16];
			wr(`CKGC_OFF_PLL, d, 4'hF);
			rd(`CKGC_OFF_STATUS);
			cmpb(v[2], 1'b0);
			cmp({3'h0, pll_cfg}, {3'h0, d[29:28], d[26:16], d[15:14], d[13:8], d[7:0]});
			cmpb(pll_running, (d[7:0] != 8'h00) && (d[26:16] != 11'h000));
			cmpb(pll_div_bypass, d[7:0] == 8'h01);
			if (d[29:28] != 2'h3) cmp({29'h0, usb_div_log2}, {30'h0, d[29:28]});
			wbit(2, 1'b1);
		end
		for (int i = 0; i < 7; i++) begin
			d = {27'h0, i[2:0], i[1:0]};
			wr(`CKGC_OFF_MCK, d, 4'hF);
			cmp({27'h0, mck_cfg}, d);
			cmp({25'h0, mck_div}, 32'h1 << i);
			cmpb(mck_pll_sel, i[1:0] == 2'h3);
			wbit(3, 1'b1);
		end
		for (int i = 0; i < 4; i++) begin
			d = $random(seed) & 32'h0000001B;
			d[1:0] = i[1:0];
			wr(`CKGC_OFF_PCK_BASE + 12'(4 * i), d, 4'hF);
			cmp({27'h0, pck_cfg[i]}, d);
			cmp({25'h0, pck_div[i]}, 32'h1 << d[4:2]);
			wbit(8 + i, 1'b1);
		end
		rchk(`CKGC_OFF_STATUS, 32'h00000F0C);
		wr(`CKGC_OFF_IRQ_EN, 32'h00000F0D, 4'hF);
		rchk(`CKGC_OFF_IRQ_MASK, 32'h00000F0D);
		cmpb(irq, 1'b1);
		wr(`CKGC_OFF_IRQ_EN, 32'h0, 4'hF);
		wr(`CKGC_OFF_IRQ_DIS, 32'h00000008, 4'hF);
		rchk(`CKGC_OFF_IRQ_MASK, 32'h00000F05);
		wr(`CKGC_OFF_IRQ_DIS, 32'hFFFFFFFF, 4'hF);
		cmpb(irq, 1'b0);
		rd(12'h00C);
		cmp({30'h0, r}, 32'h2);
		wr(`CKGC_OFF_STATUS, 32'h0, 4'hF);
		cmp({30'h0, r}, 32'h2);
		wr(`CKGC_OFF_OSC_CTL, 32'h00000101, 4'h3);
		rchk(`CKGC_OFF_OSC_CTL, 32'h0);
		conclude();
	end
endmodule : ckgc_top_bench
`default_nettype wire

// file: test/ckgc_top_sva.sv
// assertions on the clock control block ports
`timescale 1ns/100ps
`default_nettype none
module ckgc_sva #(
	parameter int NUM_PCK = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] periph_clk_en,
	input wire ckgc_pkg::ckgc_pll_cfg_t pll_cfg,
	input wire logic pll_running,
	input wire logic pll_div_bypass,
	input wire logic [2:0] usb_div_log2,
	input wire ckgc_pkg::ckgc_sel_cfg_t mck_cfg,
	input wire logic mck_pll_sel,
	input wire logic [6:0] mck_div
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----
	// properties
	// ----
	property p_run;
		$stable(pll_cfg) |-> pll_running == (|pll_cfg.divider && |pll_cfg.pll_feedback_factor);
	endproperty
	a_run: assert property (p_run) else $error("pll running flag wrong");
	property p_byp;
		$stable(pll_cfg) |-> pll_div_bypass == (pll_cfg.divider == 8'h01);
	endproperty
	a_byp: assert property (p_byp) else $error("divider bypass wrong");
	property p_usb;
		$stable(pll_cfg) && pll_cfg.usb_clock_ratio != 2'h3 |-> usb_div_log2 == {1'b0, pll_cfg.usb_clock_ratio};
	endproperty
	a_usb: assert property (p_usb) else $error("usb ratio wrong");
	property p_css;
		$stable(mck_cfg) |-> mck_pll_sel == (mck_cfg.clock_source_select == 2'h3);
	endproperty
	a_css: assert property (p_css) else $error("pll select wrong");
	property p_clock_output_ratio;
		$stable(mck_cfg) && mck_cfg.clock_output_ratio != 3'h7 |-> mck_div == (7'h01 << mck_cfg.clock_output_ratio);
	endproperty
	a_clock_output_ratio: assert property (p_clock_output_ratio) else $error("master divide wrong");
	property p_pid;
		periph_clk_en[1:0] == 2'h0;
	endproperty
	a_pid: assert property (p_pid) else $error("unimplemented clock bit set");
	property p_bhold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		rvalid && !rready |=> rvalid;
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_bafter;
		awvalid && awready && wvalid && wready |=> !awready ##1 bvalid;
	endproperty
	a_bafter: assert property (p_bafter) else $error("write response late");
	c_wr: cover property (bvalid && bready);
	c_pll: cover property (mck_pll_sel && mck_div == 7'h08);
	c_run: cover property (pll_running && pll_div_bypass);
endmodule : ckgc_sva
bind ckgc_top ckgc_sva #(.NUM_PCK(NUM_PCK)) ckgc_sva_i (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .rvalid(rvalid), .rready(rready),
	.periph_clk_en(periph_clk_en), .pll_cfg(pll_cfg), .pll_running(pll_running),
	.pll_div_bypass(pll_div_bypass), .usb_div_log2(usb_div_log2), .mck_cfg(mck_cfg),
	.mck_pll_sel(mck_pll_sel), .mck_div(mck_div));
`default_nettype wire
